// file: bench/bto_exec_tb.sv
// self-checking bench for the bit-invert / overflow-branch block
// assumes rtl/bto_defs.svh on the include path and rtl compiled first
`timescale 1ns/100ps
`include "bto_defs.svh"
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin err_count++; \
    $display("BAD t=%0t got %h exp %h", $time, a, e); end end

module bto_exec_tb;
    import bto_pkg::*;

    localparam logic [1:0] OK  = 2'h0;
    localparam logic [1:0] ERR = 2'h2;

    logic        aclk, aresetn;
    logic [7:0]  awaddr, araddr;
    logic [2:0]  awprot, arprot;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata, d;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    bto_pc_t     pc_out, epc;
    logic [34:0] rq[$];
    logic [1:0]  bq[$];
    logic [34:0] e;
    logic [1:0]  eb;
    logic [7:0]  f, n;
    logic [3:0]  bk;
    logic [11:0] base;
    int          cmp_count, err_count;

    bto_exec DUT (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awprot(awprot),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arprot(arprot), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pc_out(pc_out)
    );

    initial begin
        aclk = 1'h0;
        forever #4 aclk = ~aclk;
    end

    // ----------------------------------------------------------------
    // closing and wait bound
    // ----------------------------------------------------------------
    task conclude;
        begin
            $display("comparisons %0d mismatches %0d", cmp_count, err_count);
            if (err_count == 0 && cmp_count > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask

    task guard(inout int k);
        begin
            k++;
            if (k > 200) begin
                err_count++;
                $display("BAD t=%0t wait ran out", $time);
                conclude();
            end
        end
    endtask

    // ----------------------------------------------------------------
    // bus master
    // ----------------------------------------------------------------
    task wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
        int k;
        logic fa, fw, fb;
        begin
            bq.push_back(er);
            awaddr <= a;
            wdata <= v;
            awvalid <= 1'h1;
            wvalid <= 1'h1;
            k = 0;
            fa = 1'h0;
            fw = 1'h0;
            fb = 1'h0;
            while (!(fa && fw)) begin
                @(negedge aclk);
                if (awready === 1'h1) fa = 1'h1;
                if (wready === 1'h1) fw = 1'h1;
                @(posedge aclk);
                if (fa) awvalid <= 1'h0;
                if (fw) wvalid <= 1'h0;
                guard(k);
            end
            while (!fb) begin
                @(negedge aclk);
                fb = (bvalid === 1'h1);
                @(posedge aclk);
                guard(k);
            end
        end
    endtask

    task rd(input logic [7:0] a, input logic en, input logic [31:0] ed,
            input logic [1:0] er, output logic [31:0] q);
        int k;
        logic fr;
        begin
            rq.push_back({en, er, ed});
            araddr <= a;
            arvalid <= 1'h1;
            k = 0;
            fr = 1'h0;
            while (!fr) begin
                @(negedge aclk);
                fr = (arready === 1'h1);
                @(posedge aclk);
                guard(k);
            end
            arvalid <= 1'h0;
            fr = 1'h0;
            while (!fr) begin
                @(negedge aclk);
                fr = (rvalid === 1'h1);
                q = rdata;
                @(posedge aclk);
                guard(k);
            end
        end
    endtask

    // ----------------------------------------------------------------
    // result watcher
    // ----------------------------------------------------------------
    always @(negedge aclk) begin
        if (rvalid === 1'h1 && rready === 1'h1) begin
            e = rq.pop_front();
            if (e[34]) begin
                `CHK(rdata, e[31:0])
                `CHK(rresp, e[33:32])
            end
        end
        if (bvalid === 1'h1 && bready === 1'h1) begin
            eb = bq.pop_front();
            `CHK(bresp, eb)
        end
    end

    // ----------------------------------------------------------------
    // instruction helpers
    // ----------------------------------------------------------------
    task run(input logic [15:0] ins, input logic tk, input logic [1:0] cy);
        int k;
        logic [31:0] q;
        logic        il;
        begin
            // neither opcode pattern matches: flagged as illegal
            il = (ins[15:12] != 4'h7) && (ins[15:8] != 8'he4);
            wr(`BTO_OFF_INSTR, {16'h0, ins}, OK);
            k = 0;
            q = 32'h1;
            while (q[0] !== 1'h0) begin
                rd(`BTO_OFF_STATUS, 1'h0, 32'h0, OK, q);
                guard(k);
            end
            rd(`BTO_OFF_STATUS, 1'h1, {26'h0, cy, 1'h0, il, tk, 1'h0}, OK, q);
            rd(`BTO_OFF_PC, 1'h1, {11'h0, epc}, OK, q);
            `CHK(pc_out, epc)
        end
    endtask

    task inv(input logic [2:0] b, input logic a, input logic [7:0] fa,
             input logic [11:0] ma);
        logic [7:0]  v;
        logic [31:0] q;
        begin
            v = 8'($urandom);
            wr(`BTO_OFF_MEMADDR, {20'h0, ma}, OK);
            wr(`BTO_OFF_MEMDATA, {24'h0, v}, OK);
            epc = epc + 21'h2;
            run({4'h7, b, a, fa}, 1'h0, 2'h1);
            rd(`BTO_OFF_MEMDATA, 1'h1, {24'h0, v ^ (8'h1 << b)}, OK, q);
        end
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        cmp_count = 0;
        err_count = 0;
        aresetn = 1'h0;
        awaddr = 8'h0;
        araddr = 8'h0;
        awprot = 3'h0;
        arprot = 3'h0;
        wdata = 32'h0;
        wstrb = 4'hf;
        awvalid = 1'h0;
        wvalid = 1'h0;
        arvalid = 1'h0;
        bready = 1'h1;
        rready = 1'h1;
        epc = 21'h0;
        void'($urandom(67192));
        repeat (20) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);

        rd(`BTO_OFF_PC, 1'h1, 32'h0, OK, d);
        rd(8'h20, 1'h1, 32'h0, ERR, d);
        wr(8'h20, 32'hffff_ffff, ERR);
        wr(`BTO_OFF_STATUS, 32'hffff_ffff, OK);
        rd(`BTO_OFF_STATUS, 1'h1, 32'h0, OK, d);
        $display("test reset done");

        wr(`BTO_OFF_CTRL, 32'h2, OK);
        for (int b = 0; b < 8; b++) begin
            bk = 4'($urandom);
            f = 8'($urandom);
            wr(`BTO_OFF_BANK, {28'h0, bk}, OK);
            inv(3'(b), 1'h1, f, {bk, f});
        end
        rd(`BTO_OFF_CTRL, 1'h1, 32'h2, OK, d);
        inv(3'h0, 1'h0, 8'h5f, 12'h05f);
        inv(3'h7, 1'h0, 8'h60, 12'hf60);
        $display("test bit invert done");

        wr(`BTO_OFF_CTRL, 32'h3, OK);
        base = 12'($urandom);
        wr(`BTO_OFF_IDXBASE, {20'h0, base}, OK);
        inv(3'h3, 1'h0, 8'h5f, base + 12'h05f);
        inv(3'h5, 1'h0, 8'h00, base);
        inv(3'h1, 1'h0, 8'h60, 12'hf60);
        inv(3'h2, 1'h1, 8'h10, {bk, 8'h10});
        $display("test indexed offset done");

        wr(`BTO_OFF_CTRL, 32'h0, OK);
        n = 8'($urandom);
        epc = epc + 21'h2;
        run({8'he4, n}, 1'h0, 2'h1);
        wr(`BTO_OFF_CTRL, 32'h2, OK);
        for (int i = 0; i < 4; i++) begin
            n = (i == 0) ? 8'h80 : (i == 1) ? 8'h7f :
                (i == 2) ? 8'hff : 8'($urandom);
            epc = epc + 21'h2 + {{12{n[7]}}, n, 1'h0};
            run({8'he4, n}, 1'h1, 2'h2);
        end
        rd(`BTO_OFF_CTRL, 1'h1, 32'h2, OK, d);
        epc = epc + 21'h2;
        run(16'he500, 1'h0, 2'h1);
        $display("test overflow branch done");
        conclude();
    end
endmodule

// file: rtl/bto_addr_calc.sv
// resolves the file address of a bit-invert operand
// assumes its inputs stand still while an instruction runs
`timescale 1ns/100ps
`include "bto_defs.svh"

module bto_addr_calc (
    input  wire logic               ext_en,
    input  wire logic               acc_sel,
    input  wire logic [7:0]         faddr,
    input  wire logic [3:0]         bank_sel,
    input  wire bto_pkg::bto_daddr_t idx_base,
    output bto_pkg::bto_daddr_t     daddr,
    output logic                    indexed
);
    import bto_pkg::*;

    always_comb begin
        indexed = 1'b0;
        if (acc_sel) begin
            daddr = {bank_sel, faddr};
        end else if (ext_en && faddr <= `BTO_IDX_LIMIT) begin
            indexed = 1'b1;
            daddr   = idx_base + {4'h0, faddr};
        end else if (faddr <= `BTO_IDX_LIMIT) begin
            daddr = {`BTO_ACC_LO_BANK, faddr};
        end else begin
            daddr = {`BTO_ACC_HI_BANK, faddr};
        end
    end

endmodule

// file: rtl/bto_data_mem.sv
// data memory, 4096 bytes, one write port and a registered read
// assumes a single clock, no reset on the array
`timescale 1ns/100ps

module bto_data_mem (
    input  wire logic               aclk,
    input  wire logic               we,
    input  wire bto_pkg::bto_daddr_t waddr,
    input  wire logic [7:0]         wdata,
    input  wire bto_pkg::bto_daddr_t raddr,
    output logic [7:0]              rdata_q
);
    import bto_pkg::*;

    logic [7:0] mem [0:4095];
    logic [7:0] rdata_d;

    always_comb begin
        rdata_d = mem[raddr];
    end

    always_ff @(posedge aclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata_q <= rdata_d;
    end

endmodule

// file: rtl/bto_defs.svh
// constants for the bit-invert / overflow-branch execution block
// included by the package, the bench, bto_addr_calc and bto_exec
`ifndef BTO_DEFS_SVH
`define BTO_DEFS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define BTO_OFF_CTRL     8'h00
`define BTO_OFF_INSTR    8'h04
`define BTO_OFF_STATUS   8'h08
`define BTO_OFF_PC       8'h0c
`define BTO_OFF_BANK     8'h10
`define BTO_OFF_IDXBASE  8'h14
`define BTO_OFF_MEMADDR  8'h18
`define BTO_OFF_MEMDATA  8'h1c

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define BTO_CTRL_EXT     0
`define BTO_CTRL_OVF     1
`define BTO_ST_BUSY      0
`define BTO_ST_TAKEN     1
`define BTO_ST_ILLEGAL   2
`define BTO_ST_CYC_LO    4

// ----------------------------------------------------------------
// opcodes and addressing
// ----------------------------------------------------------------
`define BTO_OPC_INV      4'h7
`define BTO_OPC_BOV      8'he4
`define BTO_IDX_LIMIT    8'h5f
`define BTO_ACC_LO_BANK  4'h0
`define BTO_ACC_HI_BANK  4'hf

// ----------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------
`define BTO_PC_RST       21'h000000
`define BTO_INSTR_RST    16'h0000
`define BTO_PC_STEP      21'h000002
`define BTO_NOP_LAST     2'h3
`define BTO_CYC_ONE      2'h1
`define BTO_CYC_TWO      2'h2

`endif

// file: rtl/bto_exec.sv
// execution block for bit invert and branch on overflow, AXI4-Lite
// assumes one clock aclk, synchronous active-low reset aresetn
//
// Overview of operation
// - opcode 0111 bbba ffffffff inverts only bit b of file f; no flags
// - access bit 1 picks bank from bank register, 0 picks access bank
// - extended set on, access bit 0, f<=95: indexed offset addressing
// - opcode 1110 0100 nnnnnnnn branches only when overflow set; no flags
// - taken target is next instruction address plus twice signed n
// - not taken: one cycle; taken: PC written in Q4, then one idle cycle of four clocks
//
// Implementation choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/100ps
`include "bto_defs.svh"

module bto_exec (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output bto_pkg::bto_pc_t pc_out
);
    import bto_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    bto_state_e  state_q,   state_d;
    logic [1:0]  nop_cnt_q, nop_cnt_d;
    logic [1:0]  ctrl_q,    ctrl_d;
    logic [15:0] instr_q,   instr_d;
    bto_pc_t     pc_q,      pc_d;
    bto_pc_t     target_q,  target_d;
    logic [3:0]  bank_q,    bank_d;
    bto_daddr_t  base_q,    base_d;
    bto_daddr_t  maddr_q,   maddr_d;
    logic [7:0]  wbuf_q,    wbuf_d;
    logic        is_inv_q,  is_inv_d;
    logic        is_bov_q,  is_bov_d;
    logic        taken_q,   taken_d;
    logic        illegal_q, illegal_d;
    logic [1:0]  cyc_q,     cyc_d;
    logic        aw_have_q, aw_have_d;
    logic [7:0]  awaddr_q,  awaddr_d;
    logic        w_have_q,  w_have_d;
    logic [31:0] wdata_q,   wdata_d;
    logic [3:0]  wstrb_q,   wstrb_d;
    logic        bvalid_q,  bvalid_d;
    logic [1:0]  bresp_q,   bresp_d;
    logic        rvalid_q,  rvalid_d;
    logic [31:0] rdata_q,   rdata_d;
    logic [1:0]  rresp_q,   rresp_d;

    logic        busy;
    logic        start;
    logic        sw_mem_we;
    logic [31:0] wr_val;
    logic [31:0] st_word;
    bto_daddr_t  core_addr;
    logic        core_we;
    logic        mem_we;
    bto_daddr_t  mem_waddr;
    bto_daddr_t  mem_raddr;
    logic [7:0]  mem_wdata;
    logic [7:0]  mem_rdata;

    // ------------------------------------------------------------
    // operand address and data memory
    // ------------------------------------------------------------
    bto_addr_calc u_addr (
        .ext_en   (ctrl_q[`BTO_CTRL_EXT]),
        .acc_sel  (instr_q[8]),
        .faddr    (instr_q[7:0]),
        .bank_sel (bank_q),
        .idx_base (base_q),
        .daddr    (core_addr),
        .indexed  ()
    );

    assign busy      = (state_q != S_IDLE);
    assign core_we   = (state_q == S_Q4) && is_inv_q;
    assign mem_we    = core_we || sw_mem_we;
    assign mem_waddr = core_we ? core_addr : maddr_q;
    assign mem_wdata = core_we ? wbuf_q : wdata_q[7:0];
    assign mem_raddr = busy ? core_addr : maddr_q;

    bto_data_mem u_mem (
        .aclk    (aclk),
        .we      (mem_we),
        .waddr   (mem_waddr),
        .wdata   (mem_wdata),
        .raddr   (mem_raddr),
        .rdata_q (mem_rdata)
    );

    assign st_word = {26'h0, cyc_q, 1'b0, illegal_q, taken_q, busy};

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb begin
        state_d   = state_q;
        nop_cnt_d = nop_cnt_q;
        ctrl_d    = ctrl_q;
        instr_d   = instr_q;
        pc_d      = pc_q;
        target_d  = target_q;
        bank_d    = bank_q;
        base_d    = base_q;
        maddr_d   = maddr_q;
        wbuf_d    = wbuf_q;
        is_inv_d  = is_inv_q;
        is_bov_d  = is_bov_q;
        taken_d   = taken_q;
        illegal_d = illegal_q;
        cyc_d     = cyc_q;
        aw_have_d = aw_have_q;
        awaddr_d  = awaddr_q;
        w_have_d  = w_have_q;
        wdata_d   = wdata_q;
        wstrb_d   = wstrb_q;
        bvalid_d  = bvalid_q;
        bresp_d   = bresp_q;
        rvalid_d  = rvalid_q;
        rdata_d   = rdata_q;
        rresp_d   = rresp_q;
        start     = 1'b0;
        sw_mem_we = 1'b0;
        wr_val    = 32'h0;

        // write channels, taken in either order
        if (s_axi_awvalid && !aw_have_q) begin
            aw_have_d = 1'b1;
            awaddr_d  = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_have_q) begin
            w_have_d = 1'b1;
            wdata_d  = s_axi_wdata;
            wstrb_d  = s_axi_wstrb;
        end
        if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        if (aw_have_q && w_have_q && !bvalid_q) begin
            aw_have_d = 1'b0;
            w_have_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = 2'b00;
            wr_val    = bto_strb(32'h0, wdata_q, wstrb_q);
            unique case (awaddr_q)
                `BTO_OFF_CTRL: begin
                    if (!busy) ctrl_d = wr_val[1:0];
                end
                `BTO_OFF_INSTR: begin
                    if (!busy) begin
                        instr_d = wr_val[15:0];
                        start   = 1'b1;
                    end
                end
                `BTO_OFF_STATUS: begin
                end
                `BTO_OFF_PC: begin
                    if (!busy) pc_d = {wr_val[20:1], 1'b0};
                end
                `BTO_OFF_BANK: begin
                    if (!busy) bank_d = wr_val[3:0];
                end
                `BTO_OFF_IDXBASE: begin
                    if (!busy) base_d = wr_val[11:0];
                end
                `BTO_OFF_MEMADDR: begin
                    if (!busy) maddr_d = wr_val[11:0];
                end
                `BTO_OFF_MEMDATA: begin
                    sw_mem_we = !busy && wstrb_q[0];
                end
                default: begin
                    bresp_d = 2'b10;
                end
            endcase
        end

        // read channel; memory data lags its address by one clock
        if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
        if (s_axi_arvalid && !rvalid_q) begin
            rvalid_d = 1'b1;
            rresp_d  = 2'b00;
            unique case (s_axi_araddr)
                `BTO_OFF_CTRL:    rdata_d = {30'h0, ctrl_q};
                `BTO_OFF_INSTR:   rdata_d = {16'h0, instr_q};
                `BTO_OFF_STATUS:  rdata_d = st_word;
                `BTO_OFF_PC:      rdata_d = {11'h0, pc_q};
                `BTO_OFF_BANK:    rdata_d = {28'h0, bank_q};
                `BTO_OFF_IDXBASE: rdata_d = {20'h0, base_q};
                `BTO_OFF_MEMADDR: rdata_d = {20'h0, maddr_q};
                `BTO_OFF_MEMDATA: rdata_d = {24'h0, mem_rdata};
                default: begin
                    rdata_d = 32'h0;
                    rresp_d = 2'b10;
                end
            endcase
        end

        // instruction cycle, one phase per clock
        unique case (state_q)
            S_IDLE: begin
                if (start) begin
                    state_d = S_Q1;
                    taken_d = 1'b0;
                end
            end
            S_Q1: begin
                is_inv_d  = (instr_q[15:12] == `BTO_OPC_INV);
                is_bov_d  = (instr_q[15:8] == `BTO_OPC_BOV);
                illegal_d = !(instr_q[15:12] == `BTO_OPC_INV ||
                              instr_q[15:8] == `BTO_OPC_BOV);
                state_d   = S_Q2;
            end
            S_Q2: begin
                state_d = S_Q3;
            end
            S_Q3: begin
                // only the selected bit flips
                wbuf_d   = mem_rdata ^ (8'h01 << instr_q[11:9]);
                target_d = bto_branch_target(pc_q, instr_q[7:0]);
                state_d  = S_Q4;
            end
            S_Q4: begin
                if (is_bov_q && ctrl_q[`BTO_CTRL_OVF]) begin
                    pc_d      = target_q;
                    taken_d   = 1'b1;
                    cyc_d     = `BTO_CYC_TWO;
                    nop_cnt_d = 2'h0;
                    state_d   = S_NOP;
                end else begin
                    pc_d    = pc_q + `BTO_PC_STEP;
                    cyc_d   = `BTO_CYC_ONE;
                    state_d = S_IDLE;
                end
            end
            S_NOP: begin
                nop_cnt_d = nop_cnt_q + 2'h1;
                if (nop_cnt_q == `BTO_NOP_LAST) begin
                    state_d = S_IDLE;
                end
            end
        endcase
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q   <= S_IDLE;
            nop_cnt_q <= 2'h0;
            ctrl_q    <= 2'h0;
            instr_q   <= `BTO_INSTR_RST;
            pc_q      <= `BTO_PC_RST;
            target_q  <= `BTO_PC_RST;
            bank_q    <= 4'h0;
            base_q    <= 12'h000;
            maddr_q   <= 12'h000;
            wbuf_q    <= 8'h00;
            is_inv_q  <= 1'b0;
            is_bov_q  <= 1'b0;
            taken_q   <= 1'b0;
            illegal_q <= 1'b0;
            cyc_q     <= 2'h0;
            aw_have_q <= 1'b0;
            awaddr_q  <= 8'h00;
            w_have_q  <= 1'b0;
            wdata_q   <= 32'h0;
            wstrb_q   <= 4'h0;
            bvalid_q  <= 1'b0;
            bresp_q   <= 2'b00;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h0;
            rresp_q   <= 2'b00;
        end else begin
            state_q   <= state_d;
            nop_cnt_q <= nop_cnt_d;
            ctrl_q    <= ctrl_d;
            instr_q   <= instr_d;
            pc_q      <= pc_d;
            target_q  <= target_d;
            bank_q    <= bank_d;
            base_q    <= base_d;
            maddr_q   <= maddr_d;
            wbuf_q    <= wbuf_d;
            is_inv_q  <= is_inv_d;
            is_bov_q  <= is_bov_d;
            taken_q   <= taken_d;
            illegal_q <= illegal_d;
            cyc_q     <= cyc_d;
            aw_have_q <= aw_have_d;
            awaddr_q  <= awaddr_d;
            w_have_q  <= w_have_d;
            wdata_q   <= wdata_d;
            wstrb_q   <= wstrb_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
            rvalid_q  <= rvalid_d;
            rdata_q   <= rdata_d;
            rresp_q   <= rresp_d;
        end
    end

    assign s_axi_awready = !aw_have_q;
    assign s_axi_wready  = !w_have_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;
    assign pc_out        = pc_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_four_phases;
        state_q == S_Q1 ##1 state_q == S_Q2 ##1
        state_q == S_Q3 ##1 state_q == S_Q4;
    endsequence

    sequence s_idle_cycle;
        state_q == S_NOP [*4];
    endsequence

    a_inv_one_bit: assert property (
        core_we |-> $onehot(mem_wdata ^ $past(mem_rdata)))
        else $error("invert changed other than one bit");
    a_flags_kept: assert property (
        busy |=> $stable(ctrl_q))
        else $error("flags moved during an instruction");
    a_bank_sel: assert property (
        core_we && instr_q[8] |-> mem_waddr == {bank_q, instr_q[7:0]})
        else $error("banked address wrong");
    a_access_hi: assert property (
        core_we && !instr_q[8] && instr_q[7:0] > `BTO_IDX_LIMIT
        |-> mem_waddr[11:8] == `BTO_ACC_HI_BANK)
        else $error("access bank address wrong");
    a_indexed_ofs: assert property (
        core_we && !instr_q[8] && ctrl_q[`BTO_CTRL_EXT] &&
        instr_q[7:0] <= `BTO_IDX_LIMIT
        |-> mem_waddr == base_q + {4'h0, instr_q[7:0]})
        else $error("indexed offset address wrong");
    a_branch_target: assert property (
        state_q == S_Q4 && is_bov_q && ctrl_q[`BTO_CTRL_OVF]
        |=> pc_q == $past(pc_q) + 21'h2 +
            {{12{instr_q[7]}}, instr_q[7:0], 1'b0})
        else $error("branch target wrong");
    a_branch_taken: assert property (
        state_q == S_Q4 && is_bov_q && ctrl_q[`BTO_CTRL_OVF]
        |=> s_idle_cycle ##1 state_q == S_IDLE)
        else $error("taken branch not two cycles");
    a_branch_skip: assert property (
        state_q == S_Q4 && !ctrl_q[`BTO_CTRL_OVF]
        |=> state_q == S_IDLE && pc_q == $past(pc_q) + 21'h2 && !taken_q)
        else $error("untaken branch misbehaved");
    a_inv_phases: assert property (
        start |=> s_four_phases ##1 (!is_inv_q || state_q == S_IDLE))
        else $error("invert not one four-phase cycle");

endmodule

// file: rtl/bto_pkg.sv
// types and helpers shared by the execution block files
// assumes bto_defs.svh is on the include path
`include "bto_defs.svh"

package bto_pkg;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [5:0] {
        S_IDLE = 6'b000001,
        S_Q1   = 6'b000010,
        S_Q2   = 6'b000100,
        S_Q3   = 6'b001000,
        S_Q4   = 6'b010000,
        S_NOP  = 6'b100000
    } bto_state_e;

    typedef logic [20:0] bto_pc_t;
    typedef logic [11:0] bto_daddr_t;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // following instruction plus twice the signed offset
    function automatic bto_pc_t bto_branch_target(input bto_pc_t pc,
                                                  input logic [7:0] n);
        bto_pc_t ofs;
        ofs = {{12{n[7]}}, n, 1'b0};
        return pc + `BTO_PC_STEP + ofs;
    endfunction

    function automatic logic [31:0] bto_strb(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0]  strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

endpackage
